// ==== common/phy_np_consts.vh ====
/*
 Register indices, field positions and reset values
 for the next page and gigabit control register bank.
 Assumes a Wishbone slave with 32-bit data, one register per word.
*/
`ifndef PHY_NP_CONSTS_VH
`define PHY_NP_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_NP_TX 8'h0E
`define IDX_NP_RX 8'h10
`define IDX_GIG_CTRL 8'h12
`define IDX_NP_LOC 8'h0C
`define IDX_INT_STAT 8'h20
`define IDX_INT_MASK 8'h21

// Next page field positions
`define NP_MORE_BIT 15
`define NP_ACK_BIT 14
`define NP_FMT_BIT 13
`define NP_COMPLY_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_CODE_MSB 10

// Gigabit control field positions
`define GC_TEST_MSB 15
`define GC_TEST_LSB 13
`define GC_MAN_EN_BIT 12
`define GC_MAN_VAL_BIT 11
`define GC_PORT_TYPE_BIT 10
`define GC_ADV_FD_BIT 9
`define GC_ADV_HD_BIT 8

// Receive location register fields
`define LOC_ABLE_BIT 6
`define LOC_SEL_BIT 5
`define LOC_PAGE_RX_BIT 1

// Interrupt status / mask fields
`define INT_PAGE_RX_BIT 0
`define INT_PAGE_TX_BIT 1
`define INT_WIDTH 2

// Reset values
`define NP_TX_CODE_RST 11'h001
`define NP_TX_FMT_RST 1'b1
`define GC_CTRL_RST 16'h0F00
`define LOC_ABLE_RST 1'b1
`define LOC_SEL_RST 1'b1

`endif

// ==== core/np_tx_sequencer.v ====
/*
 Transmit next page sequencer: holds the page written by software until
 the negotiation engine has sent it, and keeps the toggle bit.
 Assumes the engine pulses page_sent_i once per completed exchange,
 on the same clock.
*/
`timescale 1ns/1ps
module np_tx_sequencer (
  input wire clk_i,
  input wire rst_i,
  input wire page_written_i,
  input wire page_sent_i,
  output wire pending_o,
  output wire toggle_o,
  output wire sent_event_o
);

  reg pending_q;
  reg pending_d;
  reg toggle_q;
  reg toggle_d;

  always @* begin
    pending_d = pending_q;
    toggle_d = toggle_q;
    if (page_sent_i && pending_q) begin
      // A new page went out: next one must carry the other toggle
      toggle_d = ~toggle_q;
      pending_d = 1'b0;
    end
    // A fresh write wins over the completion of the old page
    if (page_written_i) begin
      pending_d = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pending_q <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
      toggle_q <= toggle_d;
    end
  end

  assign pending_o = pending_q;
  assign toggle_o = toggle_q;
  assign sent_event_o = page_sent_i & pending_q;

endmodule // np_tx_sequencer

// ==== core/phy_next_page_gig_control.v ====
/*
 Next page and gigabit_copper_control register bank of one copper port,
 reached over a classic Wishbone slave with 32-bit data.
 Assumes the negotiation engine and the role resolution logic run on
 clk_i; their inputs are used without synchronisers.
*/
`timescale 1ns/1ps
`include "phy_np_consts.vh"
module phy_next_page_gig_control #(
  parameter ADDR_WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  // Wishbone classic slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [ADDR_WIDTH-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  // Negotiation engine side
  input wire page_rx_valid_i,
  input wire [15:0] page_rx_data_i,
  input wire page_tx_done_i,
  output wire [15:0] page_tx_data_o,
  output wire page_tx_pending_o,
  output wire partner_ability_load_o,
  output wire [15:0] partner_ability_data_o,
  // Gigabit control outputs
  input wire auto_role_master_i,
  output wire [2:0] test_mode_o,
  output wire role_master_o,
  output wire port_type_repeater_o,
  output wire adv_gig_full_o,
  output wire adv_gig_half_o,
  output wire irq_o
);

  // Decoded test mode numbers
  localparam [2:0] MODE_NORMAL = 3'h0;
  localparam [2:0] MODE_WAVEFORM = 3'h1;
  localparam [2:0] MODE_MASTER_JITTER = 3'h2;
  localparam [2:0] MODE_SLAVE_JITTER = 3'h3;
  localparam [2:0] MODE_DISTORTION = 3'h4;

  // Bus handshake
  reg ack_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  wire req;
  wire wr_commit;
  wire rd_commit;
  wire [ADDR_WIDTH-3:0] idx;
  wire [15:0] wmask;

  // Transmit page fields
  reg more_pages_q;
  reg page_format_q;
  reg message_comply_flag_q;
  reg [10:0] tx_code_q;
  wire toggle;
  wire tx_written;
  wire tx_sent_evt;
  wire [15:0] tx_word;

  // Received page and location control
  reg [15:0] rx_page_q;
  reg loc_able_q;
  reg loc_sel_q;
  reg page_rx_flag_q;
  reg ability_load_q;
  reg [15:0] ability_data_q;
  wire store_in_rx_reg;

  // Gigabit control fields
  reg [2:0] test_field_q;
  reg man_en_q;
  reg man_val_q;
  reg port_type_select_q;
  reg adv_fd_q;
  reg adv_hd_q;
  reg [2:0] test_mode_q;
  reg [2:0] test_mode_d;
  reg role_master_q;
  wire [15:0] gig_word;
  wire [15:0] gig_rst;

  // Interrupt registers
  reg [`INT_WIDTH-1:0] int_stat_q;
  reg [`INT_WIDTH-1:0] int_stat_d;
  reg [`INT_WIDTH-1:0] int_mask_q;
  reg [`INT_WIDTH-1:0] int_mask_d;
  reg irq_q;
  wire [`INT_WIDTH-1:0] int_events;

  // Request taken at the first edge; write and read complete at the
  // edge where the master sees ack high
  assign req = cyc_i & stb_i;
  assign wr_commit = req & ack_q & we_i;
  assign rd_commit = req & ack_q & ~we_i;
  assign idx = adr_i[ADDR_WIDTH-1:2];
  // Only lanes 0 and 1 reach the 16-bit registers
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Transmit page word as software and the engine see it
  assign tx_word = {more_pages_q, 1'b0, page_format_q,
                    message_comply_flag_q, toggle, tx_code_q};

  assign tx_written = wr_commit &&
                      (idx == `IDX_NP_TX) && (sel_i[1:0] != 2'b00);

  always @(posedge clk_i) begin
    if (rst_i) begin
      more_pages_q <= 1'b0;
      page_format_q <= `NP_TX_FMT_RST;
      message_comply_flag_q <= 1'b0;
      tx_code_q <= `NP_TX_CODE_RST;
    end else if (wr_commit && (idx == `IDX_NP_TX)) begin
      if (wmask[`NP_MORE_BIT]) begin
        more_pages_q <= dat_i[`NP_MORE_BIT];
      end
      if (wmask[`NP_FMT_BIT]) begin
        page_format_q <= dat_i[`NP_FMT_BIT];
      end
      if (wmask[`NP_COMPLY_BIT]) begin
        message_comply_flag_q <= dat_i[`NP_COMPLY_BIT];
      end
      if (wmask[`NP_CODE_MSB]) begin
        tx_code_q[10:8] <= dat_i[10:8];
      end
      if (wmask[0]) begin
        tx_code_q[7:0] <= dat_i[7:0];
      end
    end
  end

  // Pending flag and toggle bit live in the sequencer
  np_tx_sequencer u_np_tx_sequencer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .page_written_i(tx_written),
    .page_sent_i(page_tx_done_i),
    .pending_o(page_tx_pending_o),
    .toggle_o(toggle),
    .sent_event_o(tx_sent_evt)
  );

  // Engine reads the page straight from the register bits
  assign page_tx_data_o = tx_word;

  // Location control: when not able, pages go to the received register
  assign store_in_rx_reg = ~loc_able_q | loc_sel_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      loc_able_q <= `LOC_ABLE_RST;
      loc_sel_q <= `LOC_SEL_RST;
    end else if (wr_commit && (idx == `IDX_NP_LOC) && sel_i[0]) begin
      // Both location fields sit in lane 0
      loc_able_q <= dat_i[`LOC_ABLE_BIT];
      loc_sel_q <= dat_i[`LOC_SEL_BIT];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_page_q <= 16'h0000;
      ability_load_q <= 1'b0;
      ability_data_q <= 16'h0000;
    end else begin
      ability_load_q <= 1'b0;
      if (page_rx_valid_i) begin
        // Pages not kept here are handed to the ability register
        if (store_in_rx_reg) begin
          rx_page_q <= page_rx_data_i;
        end else begin
          ability_load_q <= 1'b1;
          ability_data_q <= page_rx_data_i;
        end
      end
    end
  end

  assign partner_ability_load_o = ability_load_q;
  assign partner_ability_data_o = ability_data_q;

  // Latching page-received flag; a new page beats the clearing read
  always @(posedge clk_i) begin
    if (rst_i) begin
      page_rx_flag_q <= 1'b0;
    end else if (page_rx_valid_i) begin
      page_rx_flag_q <= 1'b1;
    end else if (rd_commit && (idx == `IDX_NP_LOC)) begin
      page_rx_flag_q <= 1'b0;
    end
  end

  // Reset image of the gigabit control word
  assign gig_rst = `GC_CTRL_RST;

  // Gigabit control register
  always @(posedge clk_i) begin
    if (rst_i) begin
      test_field_q <= gig_rst[`GC_TEST_MSB:`GC_TEST_LSB];
      man_en_q <= gig_rst[`GC_MAN_EN_BIT];
      man_val_q <= gig_rst[`GC_MAN_VAL_BIT];
      port_type_select_q <= gig_rst[`GC_PORT_TYPE_BIT];
      adv_fd_q <= gig_rst[`GC_ADV_FD_BIT];
      adv_hd_q <= gig_rst[`GC_ADV_HD_BIT];
    end else if (wr_commit && (idx == `IDX_GIG_CTRL) && sel_i[1]) begin
      // Whole field kept, don't-care bits included
      test_field_q <= dat_i[`GC_TEST_MSB:`GC_TEST_LSB];
      man_en_q <= dat_i[`GC_MAN_EN_BIT];
      man_val_q <= dat_i[`GC_MAN_VAL_BIT];
      port_type_select_q <= dat_i[`GC_PORT_TYPE_BIT];
      adv_fd_q <= dat_i[`GC_ADV_FD_BIT];
      adv_hd_q <= dat_i[`GC_ADV_HD_BIT];
    end
  end

  assign gig_word = {test_field_q, man_en_q, man_val_q,
                     port_type_select_q, adv_fd_q, adv_hd_q,
                     8'h00};

  // Test mode decode; any code with the top bit set is mode 4
  always @* begin
    if (test_field_q[2]) begin
      test_mode_d = MODE_DISTORTION;
    end else if (test_field_q == 3'h3) begin
      test_mode_d = MODE_SLAVE_JITTER;
    end else if (test_field_q == 3'h2) begin
      test_mode_d = MODE_MASTER_JITTER;
    end else if (test_field_q == 3'h1) begin
      test_mode_d = MODE_WAVEFORM;
    end else begin
      test_mode_d = MODE_NORMAL;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      test_mode_q <= MODE_NORMAL;
      role_master_q <= 1'b0;
    end else begin
      test_mode_q <= test_mode_d;
      // Manual value only counts while manual selection is on
      role_master_q <= man_en_q ? man_val_q
                                : auto_role_master_i;
    end
  end

  assign test_mode_o = test_mode_q;
  assign role_master_o = role_master_q;
  assign port_type_repeater_o = port_type_select_q;
  assign adv_gig_full_o = adv_fd_q;
  assign adv_gig_half_o = adv_hd_q;

  // Interrupts: sticky status, write one to clear, event wins
  assign int_events = {tx_sent_evt, page_rx_valid_i};

  always @* begin
    int_stat_d = int_stat_q;
    int_mask_d = int_mask_q;
    if (wr_commit && (idx == `IDX_INT_STAT) && sel_i[0]) begin
      int_stat_d = int_stat_q & ~dat_i[`INT_WIDTH-1:0];
    end
    // Mask follows a write at once so irq never lags it
    if (wr_commit && (idx == `IDX_INT_MASK) && sel_i[0]) begin
      int_mask_d = dat_i[`INT_WIDTH-1:0];
    end
    int_stat_d = int_stat_d | int_events;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_q <= {`INT_WIDTH{1'b0}};
      int_mask_q <= {`INT_WIDTH{1'b0}};
      irq_q <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      irq_q <= |(int_stat_d & int_mask_d);
    end
  end

  assign irq_o = irq_q;

  // Read data captured at the taking edge; unmapped reads return zero
  always @* begin
    rdata_d = 32'h00000000;
    if (idx == `IDX_NP_TX) begin
      rdata_d = {16'h0000, tx_word};
    end else if (idx == `IDX_NP_RX) begin
      rdata_d = {16'h0000, rx_page_q};
    end else if (idx == `IDX_GIG_CTRL) begin
      rdata_d = {16'h0000, gig_word};
    end else if (idx == `IDX_NP_LOC) begin
      // Flag is shown here before its read-clear lands
      rdata_d[`LOC_ABLE_BIT] = loc_able_q;
      rdata_d[`LOC_SEL_BIT] = loc_sel_q;
      rdata_d[`LOC_PAGE_RX_BIT] = page_rx_flag_q;
    end else if (idx == `IDX_INT_STAT) begin
      rdata_d[`INT_WIDTH-1:0] = int_stat_q;
    end else if (idx == `IDX_INT_MASK) begin
      rdata_d[`INT_WIDTH-1:0] = int_mask_q;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else if (req & ~ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign dat_o = rdata_q;
  assign ack_o = ack_q;

endmodule // phy_next_page_gig_control

// ==== verif/np_link_partner.sv ====
/*
 Link partner and negotiation engine stand-in for the page exchange.
 Same clock as the bank; finishes a pending page delay_i + 1 cycles after pending rises.
*/
`timescale 1ns/1ps
module np_link_partner (
  input wire clk_i,
  input wire rst_i,
  input wire page_tx_pending_i,
  input wire [3:0] delay_i,
  input wire send_i,
  input wire [15:0] send_data_i,
  output reg page_tx_done_o,
  output reg page_rx_valid_o,
  output reg [15:0] page_rx_data_o
);
  reg [3:0] wait_q;
  always @(posedge clk_i) begin
    page_tx_done_o <= 1'b0;
    page_rx_valid_o <= send_i;
    // Data is meaningless outside a valid pulse, so keep it moving
    page_rx_data_o <= send_i ? send_data_i : ~page_rx_data_o;
    if (rst_i) begin
      page_rx_data_o <= 16'h0000;
      page_rx_valid_o <= 1'b0;
    end
    if (rst_i || !page_tx_pending_i || page_tx_done_o) begin
      wait_q <= delay_i;
    end else if (wait_q == 4'h0) begin
      page_tx_done_o <= 1'b1;
    end else begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule // np_link_partner

// ==== verif/phy_next_page_gig_control_chk.sv ====
/*
 Assertion checker for the next page and gigabit control bank.
 Bound into the design top; sees only its ports, one clock domain.
*/
`timescale 1ns/1ps
module phy_next_page_gig_control_chk #(
  parameter ADDR_WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [ADDR_WIDTH-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire page_tx_done_i,
  input wire [15:0] page_tx_data_o,
  input wire page_tx_pending_o,
  input wire auto_role_master_i,
  input wire [2:0] test_mode_o,
  input wire role_master_o,
  input wire port_type_repeater_o,
  input wire adv_gig_full_o,
  input wire adv_gig_half_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire acked = cyc_i && stb_i && ack_o;
  wire wr_gig = acked && we_i && adr_i == 8'h48 && sel_i[1];
  wire wr_tx = acked && we_i && adr_i == 8'h38 && sel_i[1];
  wire sent = page_tx_pending_o && page_tx_done_i;
  reg [4:0] gig_q;
  wire [2:0] mode_exp = gig_q[4] ? 3'h4 : {1'b0, gig_q[3:2]};
  wire role_exp = gig_q[1] ? gig_q[0] : auto_role_master_i;
  wire [2:0] bits_out = {port_type_repeater_o, adv_gig_full_o,
    adv_gig_half_o};
  // Shadow of control bits 15:11 as software last wrote them
  always @(posedge clk_i) begin
    if (rst_i) begin
      gig_q <= 5'h01;
    end else if (wr_gig) begin
      gig_q <= dat_i[15:11];
    end
  end
  property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_mode; wr_gig |=> ##1 test_mode_o == mode_exp; endproperty
  a_mode: assert property (p_mode) else $error("test mode");
  property p_bits; wr_gig |=> bits_out == $past(dat_i[10:8]); endproperty
  a_bits: assert property (p_bits) else $error("gig bits");
  property p_role;
    !$past(rst_i) |-> role_master_o == $past(role_exp);
  endproperty
  a_role: assert property (p_role) else $error("role");
  property p_pend; wr_tx |=> ##[0:1] page_tx_pending_o; endproperty
  a_pend: assert property (p_pend) else $error("pending");
  property p_tog;
    sent |=> page_tx_data_o[11] != $past(page_tx_data_o[11]);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle");
  property p_rsv;
    acked && !we_i && adr_i == 8'h48 |-> dat_o[7:0] == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  c_sent: cover property (sent);
  c_mode4: cover property (wr_gig && dat_i[15]);
  c_rd_rx: cover property (acked && !we_i && adr_i == 8'h40);
endmodule // phy_next_page_gig_control_chk

bind phy_next_page_gig_control phy_next_page_gig_control_chk #(
  .ADDR_WIDTH(ADDR_WIDTH)
) u_chk (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
  .ack_o, .page_tx_done_i, .page_tx_data_o, .page_tx_pending_o,
  .auto_role_master_i, .test_mode_o, .role_master_o,
  .port_type_repeater_o, .adv_gig_full_o, .adv_gig_half_o
);

// ==== verif/phy_next_page_gig_control_tb_top.sv ====
/*
 Self-checking bench for the next page and gigabit control bank.
 Wishbone master tasks plus a link partner model, 50 MHz clock.
*/
`timescale 1ns/1ps
module phy_next_page_gig_control_tb_top;
  reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  reg we_i = 1'b0, auto_role_master_i = 1'b0, send = 1'b0;
  reg [7:0] adr_i = 8'h00;
  reg [3:0] sel_i = 4'h0, delay = 4'h0;
  reg [31:0] dat_i = 32'h00000000;
  reg [15:0] send_data = 16'h0000;
  wire [31:0] dat_o;
  wire ack_o, page_rx_valid_i, page_tx_done_i, page_tx_pending_o;
  wire partner_ability_load_o, role_master_o, port_type_repeater_o;
  wire adv_gig_full_o, adv_gig_half_o, irq_o;
  wire [15:0] page_rx_data_i, page_tx_data_o, partner_ability_data_o;
  wire [2:0] test_mode_o;
  wire [2:0] bits = {port_type_repeater_o, adv_gig_full_o, adv_gig_half_o};
  logic [31:0] rnd = 32'h846A975A;
  logic [15:0] exp_q[$];
  logic [15:0] p, d;
  logic t = 1'b0, r;
  int errors = 0, total_checks = 0, cycles = 0, n, loads = 0;
  always #10 clk_i = ~clk_i;
  phy_next_page_gig_control u_phy_next_page_gig_control (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .page_rx_valid_i, .page_rx_data_i, .page_tx_done_i,
    .page_tx_data_o, .page_tx_pending_o, .partner_ability_load_o,
    .partner_ability_data_o, .auto_role_master_i, .test_mode_o,
    .role_master_o, .port_type_repeater_o, .adv_gig_full_o,
    .adv_gig_half_o, .irq_o
  );
  np_link_partner u_np_link_partner (
    .clk_i, .rst_i, .page_tx_pending_i(page_tx_pending_o),
    .delay_i(delay), .send_i(send), .send_data_i(send_data),
    .page_tx_done_o(page_tx_done_i), .page_rx_valid_o(page_rx_valid_i),
    .page_rx_data_o(page_rx_data_i)
  );
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [15:0] v, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {16'h0000, v};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 16'h0000, 4'h3);
  endtask
  task automatic send_pg(input logic [15:0] v);
    @(posedge clk_i);
    send <= 1'b1;
    send_data <= v;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // Read results are matched against the oldest expectation
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
    if (cyc_i && stb_i && !we_i && ack_o === 1'b1) begin
      chk("read_data", exp_q.pop_front(), dat_o[15:0]);
    end
    if (partner_ability_load_o === 1'b1) begin
      loads++;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h38, 16'h2001);
    rd(8'h40, 16'h0000);
    rd(8'h48, 16'h0F00);
    rd(8'h30, 16'h0060);
    rd(8'hFC, 16'h0000);
    wb(1'b1, 8'h40, 16'hFFFF, 4'h3);
    rd(8'h40, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      p = rnd[15:0];
      delay <= rnd[19:16];
      wb(1'b1, 8'h38, p, 4'h3);
      d = {p[15], 1'b0, p[13:12], t, p[10:0]};
      @(negedge clk_i);
      chk("tx_word", d, page_tx_data_o);
      n = 0;
      while (page_tx_done_i !== 1'b1 && n < 40) begin
        @(negedge clk_i);
        n++;
      end
      @(negedge clk_i);
      t = ~t;
      chk("toggle", {15'h0000, t}, {15'h0000, page_tx_data_o[11]});
      rd(8'h38, {d[15:12], t, d[10:0]});
    end
    // Writes to 0x00 and 0x60 before any test mode entry; the bank maps neither address
    wb(1'b1, 8'h00, 16'h0040, 4'h3);
    wb(1'b1, 8'h60, 16'h0000, 4'h2);
    for (int m = 0; m < 8; m++) begin
      rnd = xs(rnd);
      d = {m[2:0], m[0], rnd[11:0]};
      wb(1'b1, 8'h48, d, 4'h2);
      auto_role_master_i <= rnd[20];
      rd(8'h48, {d[15:8], 8'h00});
      @(negedge clk_i);
      r = d[12] ? d[11] : auto_role_master_i;
      p = {13'h0000, m[2] ? 3'h4 : m[2:0]};
      chk("mode", p, {13'h0000, test_mode_o});
      chk("gig_bits", {13'h0000, d[10:8]}, {13'h0000, bits});
      chk("role", {15'h0000, r}, {15'h0000, role_master_o});
    end
    // Status cleared first so the page event alone raises irq
    wb(1'b1, 8'h80, 16'h0003, 4'h1);
    wb(1'b1, 8'h84, 16'h0003, 4'h1);
    @(negedge clk_i);
    chk("irq", 16'h0000, {15'h0000, irq_o});
    rnd = xs(rnd);
    p = rnd[15:0];
    send_pg(p);
    chk("irq", 16'h0001, {15'h0000, irq_o});
    rd(8'h40, p);
    rd(8'h30, 16'h0062);
    rd(8'h30, 16'h0060);
    rd(8'h80, 16'h0001);
    wb(1'b1, 8'h80, 16'h0003, 4'h1);
    rd(8'h80, 16'h0000);
    @(negedge clk_i);
    chk("irq", 16'h0000, {15'h0000, irq_o});
    wb(1'b1, 8'h84, 16'h0000, 4'h1);
    wb(1'b1, 8'h30, 16'h0040, 4'h1);
    send_pg(~p);
    chk("irq", 16'h0000, {15'h0000, irq_o});
    chk("ability", ~p, partner_ability_data_o);
    rd(8'h40, p);
    rd(8'h30, 16'h0042);
    wb(1'b1, 8'h30, 16'h0000, 4'h1);
    rnd = xs(rnd);
    send_pg(rnd[15:0]);
    rd(8'h30, 16'h0002);
    rd(8'h40, rnd[15:0]);
    @(negedge clk_i);
    chk("ability_load", 16'h0001, loads[15:0]);
    chk("pending_reads", 16'h0000, 16'(exp_q.size()));
    final_report();
  end
endmodule // phy_next_page_gig_control_tb_top
